// ---- common/prbert_pkg.sv ----
// Shared constants, types and carriers of the PRBS-23 bit error tester.
// Assumes a single 200 MHz clock; rates come only from clock enables.
package prbert_pkg;

    // ------------------------------------------------------------------
    // Widths and timing
    // ------------------------------------------------------------------
    localparam int WORD_W = 16;
    localparam int BYTE_W = 8;
    localparam int LFSR_W = 23;
    localparam int LFSR_TAP_A = 22;
    localparam int LFSR_TAP_B = 17;
    localparam int BITS_W = 64;
    localparam int ERRS_W = 32;
    localparam int ZERO_W = 16;
    localparam int DROPS_W = 8;
    localparam int CLK_MHZ = 200;
    localparam int CLK_PERIOD_PS = 1000000 / CLK_MHZ;

    // ------------------------------------------------------------------
    // Lock thresholds and bit count step
    // ------------------------------------------------------------------
    localparam logic [ZERO_W-1:0] ZERO_LOSS_LIMIT = 16'h003F;
    localparam logic [ZERO_W-1:0] ZERO_ACQ_LIMIT = 16'h0018;
    localparam logic [3:0] ACQ_BYTES = 4'hA;
    localparam logic [5:0] TRACK_BYTES = 6'h20;
    localparam logic [ERRS_W-1:0] TRACK_ERR_LIMIT = 32'h0000_0020;
    localparam logic [BITS_W-1:0] BITS_PER_BYTE = 64'h0000_0000_0000_0008;

    // ------------------------------------------------------------------
    // State machines
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        PRBERT_SPLIT_UPPER = 2'b00,
        PRBERT_SPLIT_LOWER = 2'b01
    } prbert_split_e;

    typedef enum logic [2:0] {
        PRBERT_LOCK_IDLE = 3'b000,
        PRBERT_LOCK_WAIT = 3'b001,
        PRBERT_LOCK_ACQ = 3'b010,
        PRBERT_LOCK_TRACK = 3'b011,
        PRBERT_LOCK_CHECK = 3'b100,
        PRBERT_LOCK_LOST = 3'b101
    } prbert_lock_e;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic lock_dropped;
        logic [DROPS_W-1:0] lock_drop_total;
        logic [1:0] fsm_fault_pair;
    } prbert_status_s;

    typedef struct packed {
        logic [BITS_W-1:0] bits;
        logic [ERRS_W-1:0] errors;
    } prbert_counts_s;

endpackage : prbert_pkg

// ---- core/prbert_fifo.sv ----
// Small valid/ready FIFO built from flip-flops.
// Assumes both sides share clk and the clock enable.
`timescale 1ns/1ps
module prbert_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    initial begin
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin
            $error("FIFO depth must be a power of two of at least 2.");
        end
    end

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] cnt;
    } prbert_fifo_s;

    prbert_fifo_s st_q, st_d;
    logic push, pop;

    assign in_ready = (st_q.cnt != (AW+1)'(DEPTH));
    assign out_valid = (st_q.cnt != '0);
    assign out_data = st_q.mem[st_q.rd];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        st_d = st_q;
        if (push) begin
            st_d.mem[st_q.wr] = in_data;
            st_d.wr = st_q.wr + 1'b1;
        end
        if (pop) begin
            st_d.rd = st_q.rd + 1'b1;
        end
        st_d.cnt = st_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_q <= '0;
        end else if (ce) begin
            st_q <= st_d;
        end
    end
endmodule : prbert_fifo

// ---- core/prbert_tester.sv ----
// PRBS-23 receive bit error tester: word split, local generator, lock control, counters.
// Assumes rx_word arrives from logic on clk, qualified by word_rate_enable.
`timescale 1ns/1ps
module prbert_tester (
    // Clock, reset, freeze
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    // Rate enables
    input wire logic byte_rate_enable,
    input wire logic word_rate_enable,
    // Control
    input wire logic tester_enable,
    input wire logic flag_clear,
    // Received data
    input wire logic [prbert_pkg::WORD_W-1:0] rx_word,
    output logic rx_ready,
    // Status
    output logic locked,
    output prbert_pkg::prbert_status_s status,
    output prbert_pkg::prbert_counts_s counts
);
    localparam int BW = prbert_pkg::BYTE_W;
    localparam int LW = prbert_pkg::LFSR_W;

    typedef struct packed {
        prbert_pkg::prbert_split_e split;
        logic [BW-1:0] lo_byte;
        logic have_byte;
        logic [BW-1:0] cur_byte;
        logic cur_valid;
        logic [LW-1:0] lfsr;
        prbert_pkg::prbert_lock_e lock;
        logic [3:0] acq_cnt;
        logic [5:0] win_cnt;
        logic [prbert_pkg::ERRS_W-1:0] win_errs;
        logic acq_bad;
        logic [prbert_pkg::ZERO_W-1:0] zero_run;
        logic locked;
        prbert_pkg::prbert_status_s status;
        prbert_pkg::prbert_counts_s counts;
    } prbert_state_s;

    prbert_state_s st_q, st_d;

    logic fifo_valid, fifo_pop;
    logic [prbert_pkg::WORD_W-1:0] fifo_word;

    // ------------------------------------------------------------------
    // Word buffer
    // ------------------------------------------------------------------
    // Words are taken on the word enable; the FIFO absorbs jitter between
    // word arrival and the byte enables that drain it.
    prbert_fifo #(
        .WIDTH(prbert_pkg::WORD_W),
        .DEPTH(4)
    ) u_fifo (
        .clk(clk),
        .resetn(resetn),
        .ce(ce),
        .in_valid(word_rate_enable),
        .in_ready(rx_ready),
        .in_data(rx_word),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_word)
    );

    assign fifo_pop = byte_rate_enable && !st_q.have_byte
                      && st_q.split == prbert_pkg::PRBERT_SPLIT_UPPER;

    // Generator advanced by eight bits; returns the new register.
    function automatic logic [LW-1:0] lfsr_step8(input logic [LW-1:0] s);
        logic [LW-1:0] r;
        r = s;
        for (int i = 0; i < BW; i++) begin
            r = {r[LW-2:0], r[prbert_pkg::LFSR_TAP_A] ^ r[prbert_pkg::LFSR_TAP_B]};
        end
        return r;
    endfunction : lfsr_step8

    function automatic logic [3:0] popcount_table(input logic [3:0] n);
        logic [3:0] c;
        c = 4'h0;
        for (int i = 0; i < 4; i++) begin
            c = c + {3'h0, n[i]};
        end
        return c;
    endfunction : popcount_table

    logic [LW-1:0] lfsr_next;
    logic [BW-1:0] lfsr_byte;
    logic [3:0] upper_mismatch, lower_mismatch;
    logic [prbert_pkg::ERRS_W-1:0] byte_errs;

    assign lfsr_next = lfsr_step8(st_q.lfsr);
    assign lfsr_byte = lfsr_next[BW-1:0];
    assign upper_mismatch = st_q.cur_byte[7:4] ^ lfsr_byte[7:4];
    assign lower_mismatch = st_q.cur_byte[3:0] ^ lfsr_byte[3:0];
    assign byte_errs = 32'(popcount_table(upper_mismatch))
                       + 32'(popcount_table(lower_mismatch));

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        logic zero_acc;
        logic [prbert_pkg::ZERO_W-1:0] zr;
        st_d = st_q;
        zero_acc = 1'b0;
        zr = st_q.zero_run;
        st_d.cur_valid = 1'b0;
        if (flag_clear) begin
            st_d.status.fsm_fault_pair = 2'b00;
            st_d.status.lock_dropped = 1'b0;
        end
        // Byte split: upper byte first, lower held for the next byte enable.
        if (byte_rate_enable) begin
            case (st_q.split)
                prbert_pkg::PRBERT_SPLIT_UPPER: begin
                    if (fifo_valid) begin
                        st_d.cur_byte = fifo_word[15:8];
                        st_d.cur_valid = 1'b1;
                        st_d.lo_byte = fifo_word[7:0];
                        st_d.split = prbert_pkg::PRBERT_SPLIT_LOWER;
                    end
                end
                prbert_pkg::PRBERT_SPLIT_LOWER: begin
                    st_d.cur_byte = st_q.lo_byte;
                    st_d.cur_valid = 1'b1;
                    st_d.split = prbert_pkg::PRBERT_SPLIT_UPPER;
                end
                default: begin
                    st_d.split = prbert_pkg::PRBERT_SPLIT_UPPER;
                    st_d.status.fsm_fault_pair[1] = 1'b1;
                end
            endcase
        end
        // Checker works on the byte captured the cycle before.
        if (st_q.cur_valid) begin
            for (int i = BW - 1; i >= 0; i--) begin
                if (st_q.cur_byte[i]) begin
                    zr = '0;
                end else if (zr != '1) begin
                    zr = zr + 1'b1;
                end
                if (zr >= prbert_pkg::ZERO_ACQ_LIMIT) begin
                    zero_acc = 1'b1;
                end
            end
            st_d.zero_run = zr;
            if (st_q.locked) begin
                st_d.lfsr = lfsr_next;
                st_d.counts.bits = st_q.counts.bits + prbert_pkg::BITS_PER_BYTE;
                st_d.counts.errors = st_q.counts.errors + byte_errs;
                st_d.win_errs = st_q.win_errs + byte_errs;
            end else begin
                st_d.lfsr = {st_q.lfsr[LW-BW-1:0], st_q.cur_byte};
            end
        end
        case (st_q.lock)
            prbert_pkg::PRBERT_LOCK_IDLE: begin
                st_d.locked = 1'b0;
                if (tester_enable) begin
                    st_d.lock = prbert_pkg::PRBERT_LOCK_WAIT;
                end
            end
            prbert_pkg::PRBERT_LOCK_WAIT: begin
                st_d.acq_cnt = '0;
                st_d.acq_bad = 1'b0;
                st_d.lock = prbert_pkg::PRBERT_LOCK_ACQ;
            end
            prbert_pkg::PRBERT_LOCK_ACQ: begin
                if (st_q.cur_valid) begin
                    // Seeded bytes: after three the register predicts the data.
                    if (st_q.acq_cnt >= 4'h3 && byte_errs != '0) begin
                        st_d.acq_bad = 1'b1;
                    end
                    st_d.acq_cnt = st_q.acq_cnt + 1'b1;
                    if (zero_acc) begin
                        st_d.lock = prbert_pkg::PRBERT_LOCK_IDLE;
                    end else if (st_d.acq_cnt == prbert_pkg::ACQ_BYTES) begin
                        if (st_d.acq_bad) begin
                            st_d.lock = prbert_pkg::PRBERT_LOCK_IDLE;
                        end else begin
                            st_d.lock = prbert_pkg::PRBERT_LOCK_TRACK;
                            st_d.locked = 1'b1;
                            st_d.win_cnt = '0;
                            st_d.win_errs = '0;
                        end
                    end
                end
            end
            prbert_pkg::PRBERT_LOCK_TRACK: begin
                if (st_q.zero_run > prbert_pkg::ZERO_LOSS_LIMIT) begin
                    st_d.lock = prbert_pkg::PRBERT_LOCK_LOST;
                end else if (st_q.cur_valid) begin
                    st_d.win_cnt = st_q.win_cnt + 1'b1;
                    if (st_d.win_cnt == prbert_pkg::TRACK_BYTES) begin
                        st_d.lock = prbert_pkg::PRBERT_LOCK_CHECK;
                    end
                end
            end
            prbert_pkg::PRBERT_LOCK_CHECK: begin
                if (st_q.win_errs > prbert_pkg::TRACK_ERR_LIMIT) begin
                    st_d.lock = prbert_pkg::PRBERT_LOCK_LOST;
                end else begin
                    st_d.lock = prbert_pkg::PRBERT_LOCK_TRACK;
                end
                st_d.win_cnt = '0;
                st_d.win_errs = (st_q.cur_valid && st_q.locked) ? byte_errs : '0;
            end
            prbert_pkg::PRBERT_LOCK_LOST: begin
                // Totals are left alone so the next lock continues them.
                st_d.locked = 1'b0;
                st_d.status.lock_dropped = 1'b1;
                st_d.status.lock_drop_total = st_q.status.lock_drop_total + 1'b1;
                st_d.lock = prbert_pkg::PRBERT_LOCK_IDLE;
            end
            default: begin
                st_d.locked = 1'b0;
                st_d.lock = prbert_pkg::PRBERT_LOCK_IDLE;
                st_d.status.fsm_fault_pair[0] = 1'b1;
            end
        endcase
        if (!tester_enable) begin
            st_d.lock = prbert_pkg::PRBERT_LOCK_IDLE;
            st_d.locked = 1'b0;
        end
    end

    // All state on the one clock; ce freezes everything.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_q <= '0;
        end else if (ce) begin
            st_q <= st_d;
        end
    end

    assign locked = st_q.locked;
    assign status = st_q.status;
    assign counts = st_q.counts;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);

    a_lost_bumps_count: assert property (ce && st_q.lock == prbert_pkg::PRBERT_LOCK_LOST
        |=> status.lock_drop_total == $past(status.lock_drop_total) + 8'h01)
        else $error("Drop count not incremented on loss.");
    a_lost_sets_flag: assert property (ce && st_q.lock == prbert_pkg::PRBERT_LOCK_LOST
        |=> status.lock_dropped && !locked)
        else $error("Lost flag not set.");
    a_no_count_unlocked: assert property (!locked && !$past(locked)
        |-> $stable(counts.errors))
        else $error("Errors counted while not locked.");
    a_bits_step_eight: assert property (ce && locked && st_q.cur_valid && tester_enable
        |=> counts.bits == $past(counts.bits) + 64'h8)
        else $error("Bit count did not advance by eight.");
    // A byte still in flight in the lost cycle is counted, so the bit total may
    // step by one byte; what must never happen is a total falling back.
    a_totals_kept: assert property (ce && st_q.lock == prbert_pkg::PRBERT_LOCK_LOST
        |=> counts.bits == $past(counts.bits) + ($past(st_q.cur_valid) ? 64'h8 : 64'h0)
        && counts.errors >= $past(counts.errors))
        else $error("Totals changed on loss of lock.");
    a_zero_loss: assert property (ce && tester_enable
        && st_q.lock == prbert_pkg::PRBERT_LOCK_TRACK && st_q.zero_run > 16'h003F
        |=> st_q.lock == prbert_pkg::PRBERT_LOCK_LOST)
        else $error("Long zero run did not drop lock.");
    a_flag_clear: assert property (ce && flag_clear && st_q.lock != prbert_pkg::PRBERT_LOCK_LOST
        |=> !status.lock_dropped)
        else $error("Flag clear ignored.");
    a_upper_first: assert property (ce && byte_rate_enable && fifo_pop && fifo_valid
        |=> st_q.cur_valid && st_q.cur_byte == $past(fifo_word[15:8]))
        else $error("Upper byte not presented first.");
    a_lower_next: assert property (ce && byte_rate_enable
        && st_q.split == prbert_pkg::PRBERT_SPLIT_LOWER
        |=> st_q.cur_byte == $past(st_q.lo_byte))
        else $error("Lower byte lost.");
    a_window_errs: assert property (ce && tester_enable
        && st_q.lock == prbert_pkg::PRBERT_LOCK_CHECK && st_q.win_errs > 32'h20
        |=> st_q.lock == prbert_pkg::PRBERT_LOCK_LOST)
        else $error("Excess window errors kept lock.");

    c_lock_gained: cover property (!locked ##1 locked);
    c_lock_lost: cover property (ce && st_q.lock == prbert_pkg::PRBERT_LOCK_LOST);
    c_errors_seen: cover property (locked && st_q.cur_valid && byte_errs != '0);
    c_fifo_full: cover property (!rx_ready);
endmodule : prbert_tester

// ---- dv/prbert_prbs_src.sv ----
// Model of the receive data path: delivers 16-bit words of a 23-stage PRBS.
// Assumes take marks the edge at which the tester accepts the current word.
`timescale 1ns/1ps
module prbert_prbs_src #(
    parameter logic [22:0] SEED = 23'h2A_5A5A
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Flow control
    input wire logic take,
    // Impairments commanded by the bench
    input wire logic zero_mode,
    input wire logic [15:0] flip_mask,
    // Word toward the tester
    output logic [15:0] word
);
    logic [22:0] state_q;
    logic [22:0] state_d;
    logic [15:0] fresh;

    // The first generated bit lands in the top of the word, so the upper byte leads.
    always_comb begin
        state_d = state_q;
        fresh = 16'h0000;
        for (int i = 15; i >= 0; i--) begin
            fresh[i] = state_d[22] ^ state_d[17];
            state_d = {state_d[21:0], fresh[i]};
        end
    end

    // The sequence only advances on an accepted word, so refused pushes never lose bits.
    assign word = zero_mode ? 16'h0000 : (fresh ^ flip_mask);

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= SEED;
        end else if (take) begin
            state_q <= state_d;
        end
    end
endmodule : prbert_prbs_src

// ---- dv/test_prbert_tester.sv ----
// Self-checking bench of the PRBS-23 bit error tester.
// Assumes the source model in prbert_prbs_src and a single 200 MHz clock.
`timescale 1ns/1ps
module test_prbert_tester;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic ce = 1'b1;
    logic byte_rate_enable = 1'b0;
    logic word_rate_enable = 1'b0;
    logic tester_enable = 1'b0;
    logic flag_clear = 1'b0;
    logic zero_mode = 1'b0;
    logic [15:0] flip_mask = 16'h0000;
    logic [15:0] flip;
    logic [15:0] rx_word;
    logic rx_ready;
    logic locked;
    logic take;
    prbert_pkg::prbert_status_s status;
    prbert_pkg::prbert_counts_s counts;
    int error_cnt = 0;
    int comparisons = 0;
    int accepted = 0;
    int acc0;
    logic [31:0] seed = 32'h0001_48A2;
    logic [63:0] bits0;
    logic [31:0] errs0;
    logic [31:0] exp_errs;
    logic [7:0] drops0;

    always #2.5 clk = ~clk;

    assign take = ce && word_rate_enable && rx_ready;
    always @(posedge clk) begin
        if (take) begin
            accepted <= accepted + 1;
        end
    end

    prbert_prbs_src src (.clk(clk), .resetn(resetn), .take(take), .zero_mode(zero_mode),
        .flip_mask(flip_mask), .word(rx_word));

    prbert_tester uut (.clk(clk), .resetn(resetn), .ce(ce), .byte_rate_enable(byte_rate_enable),
        .word_rate_enable(word_rate_enable), .tester_enable(tester_enable),
        .flag_clear(flag_clear), .rx_word(rx_word), .rx_ready(rx_ready), .locked(locked),
        .status(status), .counts(counts));

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] xorshift(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xorshift

    function automatic logic [31:0] popcnt(input logic [15:0] v);
        logic [31:0] n;
        n = 32'h0000_0000;
        for (int i = 0; i < 16; i++) begin
            n = n + {31'h0000_0000, v[i]};
        end
        return n;
    endfunction : popcnt

    task check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check

    task summarize;
        if (error_cnt == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : summarize

    // One word, then its two byte enables with a random stall between them.
    task send_word(input logic [15:0] mask);
        @(posedge clk);
        word_rate_enable <= 1'b1;
        flip_mask <= mask;
        @(posedge clk);
        word_rate_enable <= 1'b0;
        byte_rate_enable <= 1'b1;
        @(posedge clk);
        seed = xorshift(seed);
        if (seed[0]) begin
            byte_rate_enable <= 1'b0;
            @(posedge clk);
            byte_rate_enable <= 1'b1;
        end
        @(posedge clk);
        byte_rate_enable <= 1'b0;
    endtask : send_word

    task send_run(input int n, input logic [15:0] mask);
        repeat (n) send_word(mask);
    endtask : send_run

    task wait_lock;
        int n;
        n = 0;
        while (locked !== 1'b1 && n < 60) begin
            send_word(16'h0000);
            n++;
        end
        check("locked", locked, 64'h1);
    endtask : wait_lock

    task settle;
        repeat (4) @(posedge clk);
    endtask : settle

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        @(negedge clk);
        check("rx_ready after reset", rx_ready, 64'h1);
        check("bits after reset", counts.bits, 64'h0);
        send_run(8, 16'h0000);
        check("locked while disabled", locked, 64'h0);
        tester_enable <= 1'b1;
        send_run(3, 16'h00FF);
        check("errors before lock", counts.errors, 64'h0);
        check("locked on garbage", locked, 64'h0);
        wait_lock();
        settle();
        bits0 = counts.bits;
        errs0 = counts.errors;
        exp_errs = popcnt(16'hF00F);
        send_word(16'hF00F);
        for (int i = 0; i < 16; i++) begin
            seed = xorshift(seed);
            flip = seed[4] ? (16'h0001 << seed[3:0]) : 16'h0000;
            exp_errs = exp_errs + popcnt(flip);
            send_word(flip);
        end
        settle();
        check("error delta", counts.errors - errs0, exp_errs);
        check("bit delta", counts.bits - bits0, 64'h110);
        check("lock kept under few errors", locked, 64'h1);
        // The buffer fills while the checker is stalled, then drains with gaps.
        bits0 = counts.bits;
        acc0 = accepted;
        @(posedge clk);
        word_rate_enable <= 1'b1;
        repeat (6) @(posedge clk);
        word_rate_enable <= 1'b0;
        @(negedge clk);
        check("words accepted", accepted - acc0, 64'h4);
        check("rx_ready when full", rx_ready, 64'h0);
        repeat (8) begin
            @(posedge clk);
            byte_rate_enable <= 1'b1;
            @(posedge clk);
            byte_rate_enable <= 1'b0;
            seed = xorshift(seed);
            repeat (seed[1:0]) @(posedge clk);
        end
        settle();
        check("rx_ready drained", rx_ready, 64'h1);
        check("bits after drain", counts.bits - bits0, 64'h40);
        check("still locked", locked, 64'h1);
        // Heavy errors drop the lock; totals survive the reacquisition.
        drops0 = status.lock_drop_total;
        errs0 = counts.errors;
        bits0 = counts.bits;
        send_run(24, 16'hFFFF);
        check("locked after burst", locked, 64'h0);
        check("lock_dropped", status.lock_dropped, 64'h1);
        wait_lock();
        check("drop total", status.lock_drop_total, drops0 + 8'h01);
        check("errors kept", (counts.errors > errs0 + 32'h20) ? 1'b1 : 1'b0, 64'h1);
        check("bits kept", (counts.bits > bits0) ? 1'b1 : 1'b0, 64'h1);
        @(posedge clk);
        flag_clear <= 1'b1;
        @(posedge clk);
        flag_clear <= 1'b0;
        @(negedge clk);
        check("lock_dropped cleared", status.lock_dropped, 64'h0);
        check("drop total after clear", status.lock_drop_total, drops0 + 8'h01);
        // A long zero run breaks the lock and must not be locked onto.
        drops0 = status.lock_drop_total;
        @(posedge clk);
        zero_mode <= 1'b1;
        send_run(20, 16'h0000);
        check("locked on zeros", locked, 64'h0);
        check("drop total zeros", status.lock_drop_total, drops0 + 8'h01);
        @(posedge clk);
        zero_mode <= 1'b0;
        wait_lock();
        check("fsm faults", status.fsm_fault_pair, 64'h0);
        @(posedge clk);
        tester_enable <= 1'b0;
        send_run(2, 16'h0000);
        check("locked after disable", locked, 64'h0);
        summarize();
    end
endmodule : test_prbert_tester
